/* File: rtl/bdp_pkg.sv */
/*
 * Constants shared by the single-wire debug target: register addresses,
 * field positions, reset values, command codes and link timing counts.
 * Assumes a 200 MHz core clock; all timing is counted in core cycles.
 */
package bdp_pkg;

	// ==========================================================
	// Register addresses
	localparam logic [17:0] PAGE_SELECT_ADDR = 18'h3FF08;
	localparam logic [17:0] FAMILY_CODE_ADDR = 18'h3FF0F;
	localparam logic [17:0] SAVED_FLAGS_ADDR = 18'h3FF06;

	// ==========================================================
	// Fields and reset values
	localparam int PAGE_ENABLE_BIT = 7;
	localparam int PAGE_INDEX_MSB = 3;
	localparam int PAGE_INDEX_LSB = 0;
	localparam logic [7:0] FLAGS_SPECIAL_RESET = 8'hD8;
	localparam logic [7:0] FLAGS_CPU_RESET = 8'hD0;
	localparam logic [7:0] FLAGS_OTHER_RESET = 8'h00;
	localparam logic [7:0] PAGE_SELECT_RESET = 8'h00;
	// Family code value is arbitrary
	localparam logic [7:0] FAMILY_CODE_DEFAULT = 8'h5A;

	// ==========================================================
	// Host command codes
	localparam logic [7:0] CMD_ENTER_DEBUG = 8'h90;
	localparam logic [7:0] CMD_ACK_ENABLE = 8'hD5;
	localparam logic [7:0] CMD_ACK_DISABLE = 8'hD6;
	localparam logic [7:0] CMD_REG_READ = 8'hE4;
	localparam logic [7:0] CMD_REG_WRITE = 8'hC4;
	localparam logic [7:0] CMD_MEM_READ = 8'hE0;
	localparam logic [7:0] CMD_MEM_WRITE = 8'hC0;
	localparam logic [7:0] CMD_SINGLE_STEP = 8'h10;
	localparam logic [7:0] CMD_GO = 8'h08;

	// ==========================================================
	// Link timing, in target clock cycles
	localparam int SYNC_LOW_CYCLES = 128;
	localparam int BIT_TIMEOUT_CYCLES = 512;
	localparam logic [9:0] SYNC_LOW_CNT = 10'(SYNC_LOW_CYCLES);
	localparam logic [9:0] BIT_TIMEOUT_CNT = 10'(BIT_TIMEOUT_CYCLES);
	localparam int BIT_SAMPLE_CYCLES = 16;
	localparam logic [9:0] BIT_SAMPLE_CNT = 10'(BIT_SAMPLE_CYCLES);
	localparam int ACK_PULSE_CYCLES = 16;
	localparam logic [4:0] ACK_PULSE_CNT = 5'(ACK_PULSE_CYCLES);

	typedef enum logic [1:0] {LINK_IDLE, LINK_LOW, LINK_SYNC, LINK_HIGH} link_state_t;

	function automatic logic is_read_cmd(input logic [7:0] cmd);
		return (cmd == CMD_REG_READ) || (cmd == CMD_MEM_READ);
	endfunction : is_read_cmd

endpackage : bdp_pkg

/* File: rtl/bdp_bit_rx.sv */
/*
 * Pin-side bit receiver: edge detection, bit sampling, sync detection
 * and the inter-edge time-out of the single debug pin.
 * Assumes the pin input is already synchronous to core_clk_i.
 */
`timescale 1ns/1ps
module bdp_bit_rx (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic nrst_i,
	// Pin and control
	input wire logic pin_i,
	input wire logic enable_i,
	input wire logic hold_i,
	// Events
	output logic bit_valid_o,
	output logic bit_data_o,
	output logic sync_o,
	output logic timeout_o
);
	bdp_pkg::link_state_t state_q;
	logic pin_q;
	logic [9:0] low_cnt_q;
	logic [9:0] edge_cnt_q;
	logic bit_valid_q;
	logic bit_data_q;
	logic sync_q;
	logic timeout_q;
	logic fall;
	logic rise;

	assign fall = pin_q && !pin_i;
	assign rise = !pin_q && pin_i;
	assign bit_valid_o = bit_valid_q;
	assign bit_data_o = bit_data_q;
	assign sync_o = sync_q;
	assign timeout_o = timeout_q;

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pin_q <= 1'b1;
		end else begin
			pin_q <= pin_i;
		end
	end

	// ==========================================================
	// Low-time and bit state
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_q <= bdp_pkg::LINK_IDLE;
			low_cnt_q <= 10'h000;
			bit_valid_q <= 1'b0;
			bit_data_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			bit_valid_q <= 1'b0;
			sync_q <= 1'b0;
			unique case (state_q)
				bdp_pkg::LINK_IDLE, bdp_pkg::LINK_HIGH: begin
					if (enable_i && fall) begin
						state_q <= bdp_pkg::LINK_LOW;
						low_cnt_q <= 10'h001;
					end
				end
				bdp_pkg::LINK_LOW: begin
					if (rise) begin // [RULE20]
						state_q <= bdp_pkg::LINK_HIGH;
						bit_valid_q <= 1'b1;
						bit_data_q <= (low_cnt_q < bdp_pkg::BIT_SAMPLE_CNT);
					end else if (low_cnt_q > bdp_pkg::SYNC_LOW_CNT) begin
						state_q <= bdp_pkg::LINK_SYNC; // [RULE18]
					end else begin
						low_cnt_q <= low_cnt_q + 10'h001;
					end
				end
				bdp_pkg::LINK_SYNC: begin
					// No time-out here: a sync waits for its rising edge forever
					if (rise) begin // [RULE19]
						state_q <= bdp_pkg::LINK_IDLE;
						sync_q <= 1'b1;
					end
				end
			endcase
		end
	end

	// ==========================================================
	// Time since the last falling edge
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			edge_cnt_q <= 10'h000;
			timeout_q <= 1'b0;
		end else begin
			timeout_q <= 1'b0;
			if (fall || state_q == bdp_pkg::LINK_IDLE || state_q == bdp_pkg::LINK_SYNC
					|| hold_i) begin
				edge_cnt_q <= 10'h000;
			end else if (edge_cnt_q >= bdp_pkg::BIT_TIMEOUT_CNT - 10'h001) begin
				edge_cnt_q <= 10'h000;
				timeout_q <= 1'b1; // [RULE21]
			end else begin
				edge_cnt_q <= edge_cnt_q + 10'h001;
			end
		end
	end

endmodule : bdp_bit_rx

/* File: rtl/bdp_target.sv */
/*
 * Single-wire debug target: command decode, saved flags and page select
 * registers, family code, single-step and low-power handling, acknowledge.
 * Assumes the core supplies flags, interrupt and low-power status, and
 * performs memory and step requests it is handed.
 */
// Contract
// RULE1 - Save processor flags on debug entry
// RULE2 - Special single-chip reset gives flags D8
// RULE3 - Other reset modes give saved flags zero
// RULE4 - Writing saved flags changes restored flags
// RULE5 - Registers reachable only by debug, unsecured
// RULE6 - Bit 7 enables paging for memory commands
// RULE7 - Register commands never use paging
// RULE8 - Bits 3-0 choose the program page
// RULE9 - Read-only family code while debug active
// RULE10 - Accept hardware and firmware command classes
// RULE11 - Pending interrupt: step only stacks
// RULE12 - Host avoids stepping the breakpoint opcode
// RULE13 - Step waits out low power; commands stay
// RULE14 - System stop blocks every debug command
// RULE15 - Leaving low power enters debug active
// RULE16 - Suppress acknowledge of low-power step
// RULE17 - System stop disables acknowledge handshake
// RULE18 - Low over 128 cycles means sync
// RULE19 - Sync waits rising edge without time-out
// RULE20 - Short low pulse is one bit
// RULE21 - 512 cycles without edge soft-resets link
// RULE22 - Uncollected read data dropped without handshake
// RULE23 - With handshake, read data is held
`timescale 1ns/1ps
module bdp_target (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic nrst_i,
	// Debug pin
	input wire logic debug_pin_i,
	output logic debug_pin_o,
	output logic debug_pin_oe_o,
	// Core status
	input wire logic special_single_chip_i,
	input wire logic secured_i,
	input wire logic [7:0] condition_flags_i,
	input wire logic irq_pending_i,
	input wire logic cpu_low_power_i,
	input wire logic system_stop_i,
	input wire logic [7:0] mem_rdata_i,
	// Core requests
	output logic debug_active_o,
	output logic [7:0] condition_flags_o,
	output logic step_o,
	output logic step_irq_only_o,
	output logic go_o,
	output logic mem_rd_o,
	output logic mem_wr_o,
	output logic [17:0] mem_addr_o,
	output logic [7:0] mem_wdata_o,
	output logic page_enable_o,
	output logic [3:0] page_index_o,
	// Host read data
	output logic [7:0] read_data_o,
	output logic read_valid_o
);
	logic bit_valid;
	logic bit_data;
	logic sync;
	logic timeout;
	logic [7:0] shift_q;
	logic [5:0] bit_cnt_q;
	logic [7:0] cmd_q;
	logic [17:0] addr_q;
	logic [7:0] flags_q;
	logic [7:0] page_q;
	logic active_q;
	logic ack_en_q;
	logic step_pend_q;
	logic ack_suppress_q;
	logic [4:0] ack_cnt_q;
	logic [7:0] rdata_q;
	logic rvalid_q;
	logic [4:0] sync_cnt_q;
	logic cmd_done;
	logic allowed;
	logic is_reg;
	logic long_done;
	logic step_ack_q;

	assign allowed = !system_stop_i; // [RULE14]
	assign is_reg = (cmd_q == bdp_pkg::CMD_REG_READ) || (cmd_q == bdp_pkg::CMD_REG_WRITE);
	// A command has 8 opcode bits; memory and register ones add 16 address and 8 data
	assign cmd_done = bit_valid && allowed
		&& ((bit_cnt_q == 6'd7 && !(shift_q[6:0] == bdp_pkg::CMD_REG_READ[7:1]
			|| shift_q[6:0] == bdp_pkg::CMD_REG_WRITE[7:1]
			|| shift_q[6:0] == bdp_pkg::CMD_MEM_READ[7:1]
			|| shift_q[6:0] == bdp_pkg::CMD_MEM_WRITE[7:1]))
		|| bit_cnt_q == 6'd31);
	// Address and data only count once the full 32-bit frame is in
	assign long_done = cmd_done && bit_cnt_q == 6'd31;

	bdp_bit_rx u_rx (
		.core_clk_i(core_clk_i),
		.nrst_i(nrst_i),
		.pin_i(debug_pin_i),
		.enable_i(allowed && !debug_pin_oe_o), // Own pulses are not host bits
		.hold_i(rvalid_q && ack_en_q), // [RULE23]
		.bit_valid_o(bit_valid),
		.bit_data_o(bit_data),
		.sync_o(sync),
		.timeout_o(timeout)
	);

	assign debug_active_o = active_q;
	assign condition_flags_o = flags_q; // [RULE4]
	assign page_enable_o = page_q[bdp_pkg::PAGE_ENABLE_BIT];
	assign page_index_o = page_q[bdp_pkg::PAGE_INDEX_MSB:bdp_pkg::PAGE_INDEX_LSB];
	assign read_data_o = rdata_q;
	assign read_valid_o = rvalid_q;
	assign debug_pin_o = 1'b0;
	assign debug_pin_oe_o = (ack_cnt_q != 5'h00) || (sync_cnt_q != 5'h00);

	// ==========================================================
	// Serial command assembly
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			shift_q <= 8'h00;
			bit_cnt_q <= 6'h00;
			cmd_q <= 8'h00;
			addr_q <= 18'h00000;
		end else if (timeout || sync || cmd_done) begin
			// Soft reset drops the partial command; cmd_q and addr_q keep their values
			bit_cnt_q <= 6'h00; // [RULE21]
			shift_q <= 8'h00;
		end else if (bit_valid && allowed) begin // [RULE10]
			shift_q <= {shift_q[6:0], bit_data};
			bit_cnt_q <= bit_cnt_q + 6'h01;
			if (bit_cnt_q == 6'd7) begin
				cmd_q <= {shift_q[6:0], bit_data};
				// Register commands sit in the debug page; the core pages memory ones
				addr_q <= ({shift_q[6:0], bit_data} == bdp_pkg::CMD_REG_READ
						|| {shift_q[6:0], bit_data} == bdp_pkg::CMD_REG_WRITE)
					? {bdp_pkg::PAGE_SELECT_ADDR[17:16], 16'h0000} : 18'h00000; // [RULE7]
			end
			if (bit_cnt_q >= 6'd8 && bit_cnt_q < 6'd24)
				addr_q[15:0] <= {addr_q[14:0], bit_data};
		end
	end

	// ==========================================================
	// Command execution
	logic [7:0] full_cmd;
	logic [7:0] data_byte;
	assign full_cmd = (bit_cnt_q == 6'd7) ? {shift_q[6:0], bit_data} : cmd_q;
	assign data_byte = {shift_q[6:0], bit_data};

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mem_rd_o <= 1'b0;
			mem_wr_o <= 1'b0;
			mem_addr_o <= 18'h00000;
			mem_wdata_o <= 8'h00;
			go_o <= 1'b0;
		end else begin
			mem_rd_o <= 1'b0;
			mem_wr_o <= 1'b0;
			go_o <= 1'b0;
			if (cmd_done && !is_reg && bit_cnt_q == 6'd31) begin
				mem_addr_o <= addr_q;
				mem_wdata_o <= data_byte;
				mem_rd_o <= (full_cmd == bdp_pkg::CMD_MEM_READ); // [RULE6]
				mem_wr_o <= (full_cmd == bdp_pkg::CMD_MEM_WRITE);
			end
			if (cmd_done && full_cmd == bdp_pkg::CMD_GO && active_q)
				go_o <= 1'b1;
		end
	end

	// ==========================================================
	// Saved flags and page select registers
	logic reg_wr;
	assign reg_wr = long_done && is_reg && cmd_q == bdp_pkg::CMD_REG_WRITE && !secured_i;

	// Special single-chip strap is caught at the first clock after release
	logic strap_done_q;
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			strap_done_q <= 1'b0;
		end else begin
			strap_done_q <= 1'b1;
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			flags_q <= bdp_pkg::FLAGS_OTHER_RESET; // [RULE3]
		end else if (!strap_done_q && special_single_chip_i) begin
			// Differs from the processor's own flags reset value
			flags_q <= bdp_pkg::FLAGS_SPECIAL_RESET; // [RULE2]
		end else if (reg_wr && addr_q == bdp_pkg::SAVED_FLAGS_ADDR) begin
			flags_q <= data_byte; // [RULE5]
		end else if (step_pend_q && !cpu_low_power_i && !active_q) begin
			flags_q <= condition_flags_i; // [RULE1]
		end else if (cmd_done && full_cmd == bdp_pkg::CMD_ENTER_DEBUG && !active_q
				&& !cpu_low_power_i) begin
			flags_q <= condition_flags_i; // [RULE1]
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			page_q <= bdp_pkg::PAGE_SELECT_RESET;
		end else if (reg_wr && addr_q == bdp_pkg::PAGE_SELECT_ADDR) begin
			page_q <= data_byte & 8'h8F; // [RULE8]
		end
	end

	// ==========================================================
	// Debug active, single step and low power
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			active_q <= 1'b0;
			step_o <= 1'b0;
			step_irq_only_o <= 1'b0;
			step_pend_q <= 1'b0;
			ack_suppress_q <= 1'b0;
			step_ack_q <= 1'b0;
		end else begin
			step_o <= 1'b0;
			step_irq_only_o <= 1'b0;
			step_ack_q <= 1'b0;
			if (!strap_done_q && special_single_chip_i) begin
				active_q <= 1'b1;
			end else if (cmd_done && full_cmd == bdp_pkg::CMD_ENTER_DEBUG
					&& !cpu_low_power_i) begin
				active_q <= 1'b1; // [RULE13]
			end else if (cmd_done && full_cmd == bdp_pkg::CMD_GO) begin
				active_q <= 1'b0;
			end else if (cmd_done && full_cmd == bdp_pkg::CMD_SINGLE_STEP && active_q) begin
				// A pending interrupt turns the step into stacking only
				step_o <= !irq_pending_i;
				step_irq_only_o <= irq_pending_i; // [RULE11]
				step_pend_q <= 1'b1;
				active_q <= 1'b0;
			end else if (step_pend_q && cpu_low_power_i) begin
				ack_suppress_q <= 1'b1; // [RULE16]
			end else if (step_pend_q && !step_o) begin
				// Core re-enters debug at the service routine on wake
				step_pend_q <= 1'b0; // [RULE15]
				active_q <= 1'b1;
				// Step acknowledge waits for the step; lost if low power was traced
				step_ack_q <= !ack_suppress_q; // [RULE16]
			end
			if (!step_pend_q)
				ack_suppress_q <= 1'b0;
		end
	end

	// ==========================================================
	// Acknowledge handshake and read data
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ack_en_q <= 1'b0;
			ack_cnt_q <= 5'h00;
			sync_cnt_q <= 5'h00;
			rdata_q <= 8'h00;
			rvalid_q <= 1'b0;
		end else begin
			if (system_stop_i)
				ack_en_q <= 1'b0; // [RULE17]
			else if (cmd_done && full_cmd == bdp_pkg::CMD_ACK_ENABLE)
				ack_en_q <= 1'b1;
			else if (cmd_done && full_cmd == bdp_pkg::CMD_ACK_DISABLE)
				ack_en_q <= 1'b0;
			if (ack_cnt_q != 5'h00)
				ack_cnt_q <= ack_cnt_q - 5'h01;
			else if (ack_en_q && ((cmd_done && full_cmd != bdp_pkg::CMD_SINGLE_STEP)
					|| step_ack_q))
				ack_cnt_q <= bdp_pkg::ACK_PULSE_CNT; // [RULE16]
			if (sync_cnt_q != 5'h00)
				sync_cnt_q <= sync_cnt_q - 5'h01;
			else if (sync)
				sync_cnt_q <= bdp_pkg::ACK_PULSE_CNT;
			if (long_done && bdp_pkg::is_read_cmd(cmd_q)) begin
				rvalid_q <= 1'b1;
				if (is_reg && secured_i)
					rdata_q <= 8'h00; // [RULE5]
				else if (is_reg && addr_q == bdp_pkg::SAVED_FLAGS_ADDR)
					rdata_q <= flags_q; // [RULE5]
				else if (is_reg && addr_q == bdp_pkg::PAGE_SELECT_ADDR)
					rdata_q <= page_q; // [RULE7]
				else if (is_reg && addr_q == bdp_pkg::FAMILY_CODE_ADDR && active_q)
					rdata_q <= bdp_pkg::FAMILY_CODE_DEFAULT; // [RULE9]
				else if (is_reg)
					rdata_q <= 8'h00; // [RULE7]
				else
					rdata_q <= mem_rdata_i;
			end else if (timeout && !ack_en_q) begin
				rvalid_q <= 1'b0; // [RULE22]
				rdata_q <= 8'h00;
			end else if (bit_valid && rvalid_q) begin
				rvalid_q <= 1'b0;
			end
		end
	end

endmodule : bdp_target

/* File: tb/bdp_host_model.sv */
/*
 * Host end of the single debug pin: bits, sync pulses, whole commands.
 * Assumes the bench resolves the open-drain pin with a pull-up.
 */
`timescale 1ns/1ps
module bdp_host_model (
	// Clock
	input wire logic core_clk_i,
	// Target drive
	input wire logic target_oe_i,
	// Host drive
	output logic pull_low_o
);
	// Idle cycles before each bit; raised by the bench for a slow host
	int gap = 8;

	initial pull_low_o = 1'b0;

	// ==========================================================
	// Pin level
	task automatic count_oe(input int span, output int n);
		n = 0;
		repeat (span) begin
			@(posedge core_clk_i);
			if (target_oe_i === 1'b1) n++;
		end
	endtask : count_oe

	task automatic send_bit(input logic b);
		repeat (gap) @(posedge core_clk_i);
		pull_low_o <= 1'b1;
		repeat (b ? 4 : 40) @(posedge core_clk_i);
		pull_low_o <= 1'b0;
	endtask : send_bit

	task automatic sync(input int low, output int n);
		pull_low_o <= 1'b1;
		repeat (low) @(posedge core_clk_i);
		pull_low_o <= 1'b0;
		count_oe(60, n);
	endtask : sync

	// ==========================================================
	// Commands
	// Only bench-chosen opcodes; the breakpoint opcode is never stepped
	task automatic send_cmd(input logic [7:0] op, input logic [23:0] tail,
			input int nbits, output int ack);
		for (int i = 7; i >= 0; i--) send_bit(op[i]);
		for (int i = 23; i >= 24 - nbits; i--) send_bit(tail[i]);
		count_oe(40, ack);
	endtask : send_cmd
endmodule : bdp_host_model

/* File: tb/bdp_target_assertions.sv */
/*
 * Checker for the debug target, watching its ports only.
 * Assumes one clock domain and the active-low asynchronous reset.
 */
`timescale 1ns/1ps
module bdp_target_checker (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic nrst_i,
	// Watched signals
	input wire logic debug_pin_i,
	input wire logic debug_pin_o,
	input wire logic debug_pin_oe_o,
	input wire logic special_single_chip_i,
	input wire logic secured_i,
	input wire logic [7:0] condition_flags_i,
	input wire logic system_stop_i,
	input wire logic debug_active_o,
	input wire logic [7:0] condition_flags_o,
	input wire logic step_o,
	input wire logic step_irq_only_o,
	input wire logic go_o,
	input wire logic mem_rd_o,
	input wire logic mem_wr_o,
	input wire logic page_enable_o,
	input wire logic [3:0] page_index_o
);
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!nrst_i);

	// ==========================================================
	// Pin
	sequence s_ack_16;
		debug_pin_oe_o[*8] ##1 debug_pin_oe_o[*8] ##1 !debug_pin_oe_o;
	endsequence

	a_ack_len: assert property ($rose(debug_pin_oe_o) |-> s_ack_16)
		else $error("target pulse not 16 cycles");
	a_ack_after_high: assert property ($rose(debug_pin_oe_o) |-> $past(debug_pin_i))
		else $error("target drove before host released pin");
	a_pin_drive: assert property (!debug_pin_o)
		else $error("pin driven high");

	// ==========================================================
	// Commands and registers
	a_stop_block: assert property (system_stop_i && $past(system_stop_i)
		|-> !(step_o || step_irq_only_o || go_o || mem_rd_o || mem_wr_o))
		else $error("request issued in system stop");
	a_step_pulse: assert property (step_o |=> !step_o)
		else $error("step request longer than one cycle");
	a_step_kind: assert property (step_irq_only_o |-> !step_o ##1 !step_irq_only_o)
		else $error("interrupt-only step mixed with step");
	a_mem_single: assert property (mem_rd_o |-> !mem_wr_o ##1 !mem_rd_o)
		else $error("memory read request malformed");
	a_secure_hold: assert property (secured_i && $past(secured_i)
		|-> $stable(page_index_o) && $stable(page_enable_o))
		else $error("page select changed while secured");
	a_entry_save: assert property (!special_single_chip_i && $rose(debug_active_o)
		|-> ##[0:1] condition_flags_o == $past(condition_flags_i))
		else $error("flags not saved on debug entry");
endmodule : bdp_target_checker

bind bdp_target bdp_target_checker chk_u (
	.core_clk_i(core_clk_i), .nrst_i(nrst_i), .debug_pin_i(debug_pin_i),
	.debug_pin_o(debug_pin_o), .debug_pin_oe_o(debug_pin_oe_o),
	.special_single_chip_i(special_single_chip_i), .secured_i(secured_i),
	.condition_flags_i(condition_flags_i), .system_stop_i(system_stop_i),
	.debug_active_o(debug_active_o), .condition_flags_o(condition_flags_o),
	.step_o(step_o), .step_irq_only_o(step_irq_only_o), .go_o(go_o),
	.mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .page_enable_o(page_enable_o),
	.page_index_o(page_index_o)
);

/* File: tb/tb_top.sv */
/*
 * Self-checking bench for the debug target with a host model on the pin.
 * Assumes the design package and the bound checker are compiled first.
 */
`timescale 1ns/1ps
module tb_top;
	logic core_clk_i;
	logic nrst_i;
	logic special_single_chip_i, secured_i, irq_pending_i, cpu_low_power_i, system_stop_i;
	logic [7:0] condition_flags_i, mem_rdata_i;
	logic pin_o, pin_oe, host_low, debug_active_o, step_o, step_irq_only_o, go_o;
	logic mem_rd_o, mem_wr_o, page_enable_o, read_valid_o;
	logic [7:0] condition_flags_o, mem_wdata_o, read_data_o;
	logic [3:0] page_index_o;
	logic [17:0] mem_addr_o;
	logic [7:0] d;
	wire pin_w;
	int seed, ack, n, checks, num_errors, n_rd, n_wr, n_step, n_irq;

	// Open drain with pull-up: released pin reads high
	assign pin_w = ~(host_low | pin_oe);

	bdp_target dut_u (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .debug_pin_i(pin_w),
		.debug_pin_o(pin_o), .debug_pin_oe_o(pin_oe),
		.special_single_chip_i(special_single_chip_i), .secured_i(secured_i),
		.condition_flags_i(condition_flags_i), .irq_pending_i(irq_pending_i),
		.cpu_low_power_i(cpu_low_power_i), .system_stop_i(system_stop_i),
		.mem_rdata_i(mem_rdata_i), .debug_active_o(debug_active_o),
		.condition_flags_o(condition_flags_o), .step_o(step_o),
		.step_irq_only_o(step_irq_only_o), .go_o(go_o), .mem_rd_o(mem_rd_o),
		.mem_wr_o(mem_wr_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
		.page_enable_o(page_enable_o), .page_index_o(page_index_o),
		.read_data_o(read_data_o), .read_valid_o(read_valid_o));
	bdp_host_model host_u (.core_clk_i(core_clk_i), .target_oe_i(pin_oe),
		.pull_low_o(host_low));

	// ==========================================================
	// Helpers
	initial begin
		core_clk_i = 1'b0;
		forever #2.5 core_clk_i = ~core_clk_i;
	end

	always @(posedge core_clk_i) begin
		if (mem_rd_o === 1'b1) n_rd++;
		if (mem_wr_o === 1'b1) n_wr++;
		if (step_o === 1'b1) n_step++;
		if (step_irq_only_o === 1'b1) n_irq++;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	task automatic test_done;
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : test_done

	task automatic cmd(input logic [7:0] op, input logic [17:0] a, input logic [7:0] v);
		bit long_op;
		long_op = (op == bdp_pkg::CMD_REG_READ) || (op == bdp_pkg::CMD_REG_WRITE)
			|| (op == bdp_pkg::CMD_MEM_READ) || (op == bdp_pkg::CMD_MEM_WRITE);
		host_u.send_cmd(op, {a[15:0], v}, long_op ? 24 : 0, ack);
	endtask : cmd

	task automatic reg_read(input logic [17:0] a, input logic [7:0] exp);
		int i;
		cmd(bdp_pkg::CMD_REG_READ, a, 8'h00);
		i = 0;
		while (read_valid_o !== 1'b1 && i < 64) begin
			@(posedge core_clk_i);
			i++;
		end
		check(read_data_o, exp);
	endtask : reg_read

	initial begin
		repeat (95000) @(posedge core_clk_i);
		num_errors++;
		test_done();
	end

	// ==========================================================
	// Scenarios
	initial begin
		seed = 90;
		nrst_i = 1'b0;
		{special_single_chip_i, secured_i, irq_pending_i, cpu_low_power_i} = 4'h0;
		system_stop_i = 1'b0;
		condition_flags_i = 8'($random(seed));
		mem_rdata_i = 8'($random(seed));
		repeat (12) @(posedge core_clk_i);
		nrst_i <= 1'b1;
		repeat (3) @(posedge core_clk_i);
		check(condition_flags_o, 8'h00);
		cmd(bdp_pkg::CMD_ENTER_DEBUG, 18'h0, 8'h00);
		check({7'h0, debug_active_o}, 8'h01);
		check(condition_flags_o, condition_flags_i);
		for (int i = 0; i < 3; i++) begin
			d = 8'($random(seed));
			host_u.gap = (i == 2) ? 150 : 8;
			cmd(bdp_pkg::CMD_REG_WRITE, bdp_pkg::SAVED_FLAGS_ADDR, d);
			check(condition_flags_o, d);
			reg_read(bdp_pkg::SAVED_FLAGS_ADDR, d);
		end
		host_u.gap = 8;
		for (int i = 0; i < 3; i++) begin
			d = (i == 0) ? 8'hFF : (i == 1) ? 8'h70 : 8'($random(seed));
			cmd(bdp_pkg::CMD_REG_WRITE, bdp_pkg::PAGE_SELECT_ADDR, d);
			check({7'h0, page_enable_o}, {7'h0, d[7]});
			check({4'h0, page_index_o}, {4'h0, d[3:0]});
			reg_read(bdp_pkg::PAGE_SELECT_ADDR, d & 8'h8F);
		end
		cpu_low_power_i <= 1'b1;
		reg_read(bdp_pkg::FAMILY_CODE_ADDR, bdp_pkg::FAMILY_CODE_DEFAULT);
		cpu_low_power_i <= 1'b0;
		d = 8'($random(seed));
		cmd(bdp_pkg::CMD_MEM_WRITE, 18'h01234, d);
		check(8'(n_wr), 8'h01);
		check(mem_wdata_o, d);
		reg_read(18'h00456, 8'h00);
		check(8'(n_rd), 8'h00);
		cmd(bdp_pkg::CMD_MEM_READ, 18'h00456, 8'h00);
		check(read_data_o, mem_rdata_i);
		repeat (600) @(posedge core_clk_i);
		check({7'h0, read_valid_o}, 8'h00);
		cmd(bdp_pkg::CMD_ACK_ENABLE, 18'h0, 8'h00);
		cmd(bdp_pkg::CMD_MEM_READ, 18'h00456, 8'h00);
		check(8'(ack), 8'h10);
		repeat (600) @(posedge core_clk_i);
		check({7'h0, read_valid_o}, 8'h01);
		irq_pending_i <= 1'b1;
		cmd(bdp_pkg::CMD_SINGLE_STEP, 18'h0, 8'h00);
		check(8'(n_irq), 8'h01);
		check(8'(n_step), 8'h00);
		irq_pending_i <= 1'b0;
		cmd(bdp_pkg::CMD_SINGLE_STEP, 18'h0, 8'h00);
		check(8'(n_step), 8'h01);
		check(8'(ack), 8'h10);
		d = {page_enable_o, 3'h0, page_index_o};
		secured_i <= 1'b1;
		cmd(bdp_pkg::CMD_REG_WRITE, bdp_pkg::PAGE_SELECT_ADDR, ~d);
		check({page_enable_o, 3'h0, page_index_o}, d);
		reg_read(bdp_pkg::PAGE_SELECT_ADDR, 8'h00);
		secured_i <= 1'b0;
		// Partial command left to time out must not reach the registers
		for (int i = 0; i < 4; i++) host_u.send_bit(i < 2);
		repeat (600) @(posedge core_clk_i);
		cmd(bdp_pkg::CMD_REG_WRITE, bdp_pkg::SAVED_FLAGS_ADDR, 8'h3C);
		check(condition_flags_o, 8'h3C);
		host_u.sync(1200, n);
		check(8'(n), 8'h10);
		system_stop_i <= 1'b1;
		cmd(bdp_pkg::CMD_SINGLE_STEP, 18'h0, 8'h00);
		check(8'(n_step), 8'h01);
		system_stop_i <= 1'b0;
		repeat (600) @(posedge core_clk_i);
		cmd(bdp_pkg::CMD_REG_WRITE, bdp_pkg::SAVED_FLAGS_ADDR, 8'h11);
		check(8'(ack), 8'h00);
		cmd(bdp_pkg::CMD_ACK_ENABLE, 18'h0, 8'h00);
		cmd(bdp_pkg::CMD_REG_WRITE, bdp_pkg::SAVED_FLAGS_ADDR, 8'h22);
		check(8'(ack), 8'h10);
		cmd(bdp_pkg::CMD_GO, 18'h0, 8'h00);
		check({7'h0, debug_active_o}, 8'h00);
		cmd(bdp_pkg::CMD_ENTER_DEBUG, 18'h0, 8'h00);
		// Traced stop: no step acknowledge, other commands still answered
		cpu_low_power_i <= 1'b1;
		cmd(bdp_pkg::CMD_SINGLE_STEP, 18'h0, 8'h00);
		check(8'(ack), 8'h00);
		cmd(bdp_pkg::CMD_ENTER_DEBUG, 18'h0, 8'h00);
		check({7'h0, debug_active_o}, 8'h00);
		cmd(bdp_pkg::CMD_REG_WRITE, bdp_pkg::SAVED_FLAGS_ADDR, 8'h5C);
		check(8'(ack), 8'h10);
		check(condition_flags_o, 8'h5C);
		cpu_low_power_i <= 1'b0;
		host_u.count_oe(40, n);
		check(8'(n), 8'h00);
		check({7'h0, debug_active_o}, 8'h01);
		check(condition_flags_o, condition_flags_i);
		// Mid-run reset in special single-chip mode
		nrst_i <= 1'b0;
		special_single_chip_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		nrst_i <= 1'b1;
		repeat (3) @(posedge core_clk_i);
		check({7'h0, debug_active_o}, 8'h01);
		check(condition_flags_o, bdp_pkg::FLAGS_SPECIAL_RESET);
		reg_read(bdp_pkg::SAVED_FLAGS_ADDR, bdp_pkg::FLAGS_SPECIAL_RESET);
		test_done();
	end
endmodule : tb_top
